// ==== hw/tmc_params.svh ====
/*
 * constants of the 8-bit timer/counter: register offsets, field
 * positions, reset values and bus response codes.
 * assumes inclusion by bare name from hw/.
 */
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// =====================================================================
// register byte addresses (aligned words)
// =====================================================================
// flags and count keep their register index; the byte address is
// four times the index so every register sits on its own word
`define TMC_IDX_FLAGS 8'h15
`define TMC_IDX_COUNT 8'h26
`define TMC_OFS_FLAGS 8'h54
`define TMC_OFS_COUNT 8'h98
`define TMC_OFS_CMPA 8'h28
`define TMC_OFS_CMPB 8'h2C
`define TMC_OFS_MASK 8'h30
`define TMC_OFS_CTRL 8'h34

// =====================================================================
// field positions
// =====================================================================
`define TMC_BIT_OVF 0
`define TMC_BIT_CMPA 1
`define TMC_BIT_CMPB 2
`define TMC_CTRL_CS_LSB 0
`define TMC_CTRL_WGM_LSB 4

// =====================================================================
// reset values, fixed counts and response codes
// =====================================================================
`define TMC_RST_BYTE 8'h00
`define TMC_MAX_COUNT 8'hFF
`define TMC_BOTTOM_COUNT 8'h00
`define TMC_RESP_OKAY 2'h0
`define TMC_RESP_SLVERR 2'h2

`endif

// ==== hw/tmc_pkg.sv ====
/*
 * types of the 8-bit timer/counter.
 * assumes tmc_params.svh is compiled alongside.
 */
package tmc_pkg;
  // waveform mode codes, in field order 0..7
  typedef enum logic [2:0] {
    TMC_NORMAL, TMC_PC_FF, TMC_CTC, TMC_FAST_FF,
    TMC_RSV4, TMC_PC_TOPA, TMC_RSV6, TMC_FAST_TOPA
  } tmc_wgm_t;

  // bus slave phases
  typedef enum logic [1:0] {TMC_IDLE, TMC_RESP} tmc_bus_t;
endpackage : tmc_pkg

// ==== hw/tmc_cmp_if.sv ====
/*
 * interface carrying the count and a compare value to a match unit.
 * assumes a single core clock.
 */
`timescale 1ns/100ps
interface tmc_cmp_if;
  logic [7:0] count; // running count
  logic [7:0] cmpVal; // compare value
  logic block; // match suppressed this tick
  logic tick; // timer clock enable
  logic hit; // registered match pulse
  modport core (output count, cmpVal, block, tick, input hit);
  modport unit (input count, cmpVal, block, tick, output hit);
endinterface : tmc_cmp_if

// ==== hw/tmc_match.sv ====
/*
 * compare unit: registers a one-cycle match pulse on a timer tick.
 * assumes the count and compare value are synchronous to core_clk.
 */
`timescale 1ns/100ps
module tmc_match
  import tmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  tmc_cmp_if.unit cmp
);
  typedef struct packed {
    logic hit;
  } tmc_match_st_t;
  tmc_match_st_t st, next_st;

  // =====================================================================
  // match on tick unless blocked by a count write
  // =====================================================================
  always_comb begin
    next_st = st;
    next_st.hit = cmp.tick && !cmp.block && (cmp.count == cmp.cmpVal);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cmp.hit = st.hit;
endmodule : tmc_match

// ==== hw/tmc_timer.sv ====
/*
 * 8-bit timer/counter register block with two compare channels,
 * overflow detection, mask and write-one-to-clear flags.
 * assumes an AXI4-Lite master on core_clk, a timer tick enable from an
 * outside clock select, and a core that pulses vector acknowledges.
 */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "tmc_params.svh"

// Notes on behaviour
// - count register readable and writable by software
// - count write blocks next tick's compare match
// - compare A continuously matched against count
// - compare B continuously matched against count
// - mask and flag bits 7:3 read zero
// - compare B irq needs mask, global, flag
// - compare A irq needs mask, global, flag
// - overflow irq needs mask, global, flag
// - flag bit 2 set on compare B match
// - flag bit 1 set on compare A match
// - flag bit 0 set on overflow
// - vector execution clears its flag
// - writing one clears flag, zero leaves it
// - overflow point follows waveform mode field
// - max, bottom or compare A top by mode
// - clock select zero stops the counter
module tmc_timer
  import tmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer clock tick from the prescaler
  input wire logic timerTick,
  // core side
  input wire logic globalIrqEnable,
  input wire logic [2:0] vectorAck,
  output logic [2:0] irqRequest,
  output logic [2:0] irqTake,
  output logic wave_out_a,
  output logic wave_out_b
);

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    logic [7:0] timer_count; // running count
    logic [7:0] compare_a_value; // compare A
    logic [7:0] compare_b_value; // compare B
    logic [2:0] timer_irq_mask; // enables
    logic [2:0] timer_irq_flags; // sticky flags
    logic [2:0] clock_select_field; // zero stops count
    logic [2:0] waveform_mode_field; // mode code
    logic countDown; // phase correct direction
    logic blockNext; // suppress match on next tick
    logic waveA; // toggles on compare A match
    logic waveB; // toggles on compare B match
    tmc_bus_t wrPh; // write channel phase
    logic awHeld; // address taken
    logic wHeld; // data taken
    logic [7:0] awAddr; // held address
    logic [31:0] wData; // held data
    logic [3:0] wStrb; // held strobes
    logic [1:0] bresp; // write answer
    tmc_bus_t rdPh; // read channel phase
    logic [31:0] rdata; // read answer data
    logic [1:0] rresp; // read answer code
  } tmc_state_t;
  // one flat struct keeps every flop under one reset and one register
  tmc_state_t st, next_st;

  // =====================================================================
  // compare units
  // =====================================================================
  tmc_cmp_if cmpA ();
  tmc_cmp_if cmpB ();
  // a tick only counts while a clock source is selected
  logic running;
  assign running = timerTick && (st.clock_select_field != 3'h0);

  assign cmpA.count = st.timer_count;
  assign cmpA.cmpVal = st.compare_a_value;
  assign cmpA.block = st.blockNext;
  assign cmpA.tick = running;
  assign cmpB.count = st.timer_count;
  assign cmpB.cmpVal = st.compare_b_value;
  assign cmpB.block = st.blockNext;
  assign cmpB.tick = running;

  // compare A continuously matched
  tmc_match uMatchA (
    .core_clk(core_clk),
    .rstn(rstn),
    .cmp(cmpA)
  );
  // compare B continuously matched
  tmc_match uMatchB (
    .core_clk(core_clk),
    .rstn(rstn),
    .cmp(cmpB)
  );

  // =====================================================================
  // helpers
  // =====================================================================
  // address decode shared by read and write paths
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `TMC_OFS_FLAGS) || (a == `TMC_OFS_COUNT) ||
      (a == `TMC_OFS_CMPA) || (a == `TMC_OFS_CMPB) ||
      (a == `TMC_OFS_MASK) || (a == `TMC_OFS_CTRL);
  endfunction : isMapped

  // top of count for the current mode
  function automatic logic [7:0] topOf(input tmc_wgm_t m,
                                       input logic [7:0] ca);
    // reserved modes fall to the default and run as normal
    case (m)
      TMC_CTC, TMC_PC_TOPA, TMC_FAST_TOPA: topOf = ca;
      default: topOf = `TMC_MAX_COUNT;
    endcase
  endfunction : topOf

  // =====================================================================
  // next state
  // =====================================================================
  tmc_wgm_t mode;
  logic [7:0] top;
  logic ovfEvent;
  logic wrFire;
  logic [2:0] setFlags;

  // one pass builds the whole next state; later lines win,
  // so the order below is also the priority order
  always_comb begin
    next_st = st;
    mode = tmc_wgm_t'(st.waveform_mode_field);
    top = topOf(mode, st.compare_a_value);
    ovfEvent = 1'b0;
    wrFire = 1'b0;
    setFlags = 3'h0;

    // counting sequence, overflow point by mode
    if (running) begin
      next_st.blockNext = 1'b0; // block lasts one tick only
      case (mode)
        TMC_PC_FF, TMC_PC_TOPA: begin
          // phase correct: overflow at bottom
          if (st.countDown) begin
            if (st.timer_count == `TMC_BOTTOM_COUNT) begin
              next_st.countDown = 1'b0;
              next_st.timer_count = st.timer_count + 8'h01;
            end else begin
              next_st.timer_count = st.timer_count - 8'h01;
              // flag raised on the step that lands on bottom
              ovfEvent = (st.timer_count == 8'h01);
            end
          end else if (st.timer_count >= top) begin
            // turn at top; >= also catches a count written above top
            next_st.countDown = 1'b1;
            next_st.timer_count = st.timer_count - 8'h01;
          end else begin
            next_st.timer_count = st.timer_count + 8'h01;
          end
        end
        TMC_FAST_TOPA: begin
          // overflow at top equal to compare A
          ovfEvent = (st.timer_count == top);
          next_st.timer_count = ovfEvent ? `TMC_BOTTOM_COUNT :
            st.timer_count + 8'h01;
        end
        TMC_CTC: begin
          // clears at compare A, flag still at max
          // a count written above top runs on to max and wraps
          ovfEvent = (st.timer_count == `TMC_MAX_COUNT);
          next_st.timer_count = (st.timer_count == top) ?
            `TMC_BOTTOM_COUNT : st.timer_count + 8'h01;
        end
        default: begin
          // normal and fixed fast pwm wrap at max
          ovfEvent = (st.timer_count == `TMC_MAX_COUNT);
          next_st.timer_count = st.timer_count + 8'h01;
        end
      endcase
    end

    // ---- simple toggle waveforms from registered matches
    if (cmpA.hit) begin
      next_st.waveA = !st.waveA;
    end
    if (cmpB.hit) begin
      next_st.waveB = !st.waveB;
    end

    // ---- flag events
    setFlags[`TMC_BIT_OVF] = ovfEvent;
    setFlags[`TMC_BIT_CMPA] = cmpA.hit;
    setFlags[`TMC_BIT_CMPB] = cmpB.hit;
    // vector clears its own flag
    next_st.timer_irq_flags = st.timer_irq_flags & ~vectorAck;

    // ---- write channel: address and data in either order
    // the store waits until both halves are held: one cycle more,
    // but the decode then never looks at live bus signals
    if (st.wrPh == TMC_IDLE) begin
      if (s_axi_awvalid && !st.awHeld) begin
        next_st.awHeld = 1'b1;
        next_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.wHeld) begin
        next_st.wHeld = 1'b1;
        next_st.wData = s_axi_wdata;
        next_st.wStrb = s_axi_wstrb;
      end
      wrFire = st.awHeld && st.wHeld;
    end else if (s_axi_bready) begin
      next_st.wrPh = TMC_IDLE;
    end

    if (wrFire) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.wrPh = TMC_RESP;
      next_st.bresp = isMapped(st.awAddr) ? `TMC_RESP_OKAY :
        `TMC_RESP_SLVERR;
      if (st.wStrb[0]) begin
        case (st.awAddr)
          `TMC_OFS_COUNT: begin
            // written value beats the increment
            next_st.timer_count = st.wData[7:0];
            next_st.blockNext = 1'b1;
          end
          `TMC_OFS_CMPA: next_st.compare_a_value = st.wData[7:0];
          `TMC_OFS_CMPB: next_st.compare_b_value = st.wData[7:0];
          // upper bits dropped, they read zero
          `TMC_OFS_MASK: next_st.timer_irq_mask = st.wData[2:0];
          `TMC_OFS_FLAGS: begin
            // write one clears, zero keeps
            next_st.timer_irq_flags = next_st.timer_irq_flags &
              ~st.wData[2:0];
          end
          `TMC_OFS_CTRL: begin
            next_st.clock_select_field =
              st.wData[`TMC_CTRL_CS_LSB +: 3];
            next_st.waveform_mode_field =
              st.wData[`TMC_CTRL_WGM_LSB +: 3];
          end
          default: begin
            // unmapped: nothing stored
          end
        endcase
      end
    end

    // events win over any clear in the same cycle
    next_st.timer_irq_flags = next_st.timer_irq_flags | setFlags;

    // ---- read channel, answer registered one cycle on
    // limitation: read data is a snapshot taken with the address
    if (st.rdPh == TMC_IDLE) begin
      if (s_axi_arvalid) begin
        next_st.rdPh = TMC_RESP;
        next_st.rresp = isMapped(s_axi_araddr) ? `TMC_RESP_OKAY :
          `TMC_RESP_SLVERR;
        case (s_axi_araddr)
          `TMC_OFS_COUNT: next_st.rdata = {24'h0, st.timer_count};
          `TMC_OFS_CMPA: next_st.rdata = {24'h0, st.compare_a_value};
          `TMC_OFS_CMPB: next_st.rdata = {24'h0, st.compare_b_value};
          // reserved bits return zero
          `TMC_OFS_MASK: next_st.rdata = {29'h0, st.timer_irq_mask};
          `TMC_OFS_FLAGS: next_st.rdata = {29'h0, st.timer_irq_flags};
          `TMC_OFS_CTRL: next_st.rdata = {25'h0,
            st.waveform_mode_field, 1'b0, st.clock_select_field};
          default: next_st.rdata = 32'h0;
        endcase
      end
    end else if (s_axi_rready) begin
      next_st.rdPh = TMC_IDLE;
    end
  end

  // =====================================================================
  // state register
  // =====================================================================
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
      st.wrPh <= TMC_IDLE;
      st.rdPh <= TMC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  // ready lines come from state only, never from a valid input
  assign s_axi_awready = (st.wrPh == TMC_IDLE) && !st.awHeld;
  assign s_axi_wready = (st.wrPh == TMC_IDLE) && !st.wHeld;
  assign s_axi_bvalid = (st.wrPh == TMC_RESP);
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = (st.rdPh == TMC_IDLE);
  assign s_axi_rvalid = (st.rdPh == TMC_RESP);
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign wave_out_a = st.waveA;
  assign wave_out_b = st.waveB;

  // per-flag request lines and global-gated take
  // the global enable gates only the take, the request stays visible
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gIrq
      // request while flag and mask both set
      assign irqRequest[gi] = st.timer_irq_flags[gi] &
        st.timer_irq_mask[gi];
      // taken only with global enable
      assign irqTake[gi] = irqRequest[gi] & globalIrqEnable;
    end
  endgenerate

endmodule : tmc_timer

// ==== tb/tmc_core_model.sv ====
/*
 * far-side model: the processor core taking timer interrupts.
 * assumes core_clk and rstn shared with the timer block.
 */
`timescale 1ns/100ps
// =====================================================================
// core model
// =====================================================================
module tmc_core_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ackOn, // core willing to enter vectors
  input wire logic [2:0] irqTake,
  output logic [2:0] vectorAck
);
  // one-cycle vector entry per taken request; the mask against the
  // last ack stops a second entry while the flag is still clearing
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      vectorAck <= 3'h0;
    end else begin
      vectorAck <= ackOn ? (irqTake & ~vectorAck) : 3'h0;
    end
  end
endmodule : tmc_core_model

// ==== tb/tmc_timer_chk.sv ====
/*
 * assertions on the timer block ports: bus answers, irq gating,
 * vector clear and reserved bits.
 * assumes binding onto tmc_timer, one clock domain.
 */
`timescale 1ns/100ps
`include "tmc_params.svh"
// =====================================================================
// checker
// =====================================================================
module tmc_timer_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic timerTick,
  input wire logic globalIrqEnable,
  input wire logic [2:0] vectorAck,
  input wire logic [2:0] irqRequest,
  input wire logic [2:0] irqTake
);
  logic [7:0] rdAddr; // address of the read under way
  // only one read outstanding, so the capture stays valid
  always_ff @(posedge core_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rdAddr <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_take_b; irqTake[2] == (irqRequest[2] && globalIrqEnable);
  endproperty
  a_take_b: assert property (p_take_b)
    else $error("compare B take not gated");
  property p_take_a; irqTake[1] == (irqRequest[1] && globalIrqEnable);
  endproperty
  a_take_a: assert property (p_take_a)
    else $error("compare A take not gated");
  property p_take_o; irqTake[0] == (irqRequest[0] && globalIrqEnable);
  endproperty
  a_take_o: assert property (p_take_o)
    else $error("overflow take not gated");
  // no set can race the clear when no tick came on the edge before
  property p_vec_a; vectorAck[1] && !$past(timerTick) |=> !irqRequest[1];
  endproperty
  a_vec_a: assert property (p_vec_a)
    else $error("compare A flag kept after vector");
  // overflow sets on the tick edge itself, so look at the present tick
  property p_vec_o; vectorAck[0] && !timerTick |=> !irqRequest[0];
  endproperty
  a_vec_o: assert property (p_vec_o)
    else $error("overflow flag kept after vector");
  property p_rsvd; s_axi_rvalid && (rdAddr == `TMC_OFS_FLAGS ||
    rdAddr == `TMC_OFS_MASK) |-> s_axi_rdata[31:3] == 29'h0; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");
  property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write answer late");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
endmodule : tmc_timer_chk
bind tmc_timer tmc_timer_chk i_chk (.core_clk(core_clk), .rstn(rstn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .timerTick(timerTick), .globalIrqEnable(globalIrqEnable),
  .vectorAck(vectorAck), .irqRequest(irqRequest), .irqTake(irqTake));

// ==== tb/test_timer8_counter_compare_irq.sv ====
/*
 * self-checking bench for the 8-bit timer register block.
 * assumes tmc_params.svh on the include path and the core model.
 */
`timescale 1ns/100ps
`include "tmc_params.svh"
module test_timer8_counter_compare_irq;
  logic core_clk, rstn, timerTick, globalIrqEnable, ackOn;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData, got;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, gotResp;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, waveA, waveB, w0;
  logic [2:0] vectorAck, irqRequest, irqTake, seenTake;
  int fails, nChecks;
  tmc_timer i_dut (.core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .timerTick(timerTick), .globalIrqEnable(globalIrqEnable),
    .vectorAck(vectorAck), .irqRequest(irqRequest), .irqTake(irqTake),
    .wave_out_a(waveA), .wave_out_b(waveB));
  tmc_core_model i_core (.core_clk(core_clk), .rstn(rstn),
    .ackOn(ackOn), .irqTake(irqTake), .vectorAck(vectorAck));
  // =====================================================================
  // clock and taken-request history
  // =====================================================================
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    seenTake <= rstn ? (seenTake | irqTake) : 3'h0;
  end
  // =====================================================================
  // helpers
  // =====================================================================
  task tally_and_finish;
    if (fails == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] g, input logic [31:0] e);
    nChecks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // bounded wait ran out: count it and stop
  task hung;
    fails++;
    $display("[ERR] %0t bus answer missing", $time);
    tally_and_finish();
  endtask : hung
  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!bValid && k < 60);
    if (!bValid) hung();
    // bready stays high: one write at a time, so nothing else answers
    chk(bResp, e);
  endtask : wr
  // read and compare data and response
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int k;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      if (arValid && arReady) arValid <= 1'b0;
    end while (!rValid && k < 60);
    if (!rValid) hung();
    chk(rData, e);
    chk(rResp, r);
  endtask : rd
  // n one-cycle ticks, then time for the flags to land
  task ticks(input int n);
    repeat (n) begin
      timerTick <= 1'b1;
      @(posedge core_clk);
      timerTick <= 1'b0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask : ticks
  // =====================================================================
  // scenarios
  // =====================================================================
  task t_reset;
    rd(`TMC_OFS_FLAGS, 32'h0, `TMC_RESP_OKAY);
    rd(`TMC_OFS_COUNT, 32'h0, `TMC_RESP_OKAY);
    rd(`TMC_OFS_MASK, 32'h0, `TMC_RESP_OKAY);
    rd(8'h00, 32'h0, `TMC_RESP_SLVERR);
    wr(8'h3C, 32'h1, `TMC_RESP_SLVERR);
  endtask : t_reset
  // stopped clock select: ticks leave the written count alone
  task t_count;
    wr(`TMC_OFS_COUNT, 32'hA5, `TMC_RESP_OKAY);
    ticks(3);
    rd(`TMC_OFS_COUNT, 32'hA5, `TMC_RESP_OKAY);
    wr(`TMC_OFS_MASK, 32'hFF, `TMC_RESP_OKAY);
    rd(`TMC_OFS_MASK, 32'h7, `TMC_RESP_OKAY);
  endtask : t_count
  task t_match;
    wr(`TMC_OFS_CTRL, 32'h01, `TMC_RESP_OKAY);
    wr(`TMC_OFS_CMPA, 32'h10, `TMC_RESP_OKAY);
    wr(`TMC_OFS_CMPB, 32'h12, `TMC_RESP_OKAY);
    wr(`TMC_OFS_COUNT, 32'h10, `TMC_RESP_OKAY);
    ticks(2);
    rd(`TMC_OFS_FLAGS, 32'h0, `TMC_RESP_OKAY);
    w0 = waveB;
    ticks(1);
    rd(`TMC_OFS_FLAGS, 32'h4, `TMC_RESP_OKAY);
    chk(waveB, !w0);
    wr(`TMC_OFS_COUNT, 32'h0F, `TMC_RESP_OKAY);
    ticks(3);
    rd(`TMC_OFS_FLAGS, 32'h6, `TMC_RESP_OKAY);
    chk(irqRequest, 3'h6);
    chk(irqTake, 3'h0);
    wr(`TMC_OFS_FLAGS, 32'h2, `TMC_RESP_OKAY);
    rd(`TMC_OFS_FLAGS, 32'h4, `TMC_RESP_OKAY);
    wr(`TMC_OFS_FLAGS, 32'h0, `TMC_RESP_OKAY);
    rd(`TMC_OFS_FLAGS, 32'h4, `TMC_RESP_OKAY);
    // tick held through a count write: the written value lands,
    // then one more tick comes before the tick is dropped
    timerTick <= 1'b1;
    wr(`TMC_OFS_COUNT, 32'h40, `TMC_RESP_OKAY);
    timerTick <= 1'b0;
    rd(`TMC_OFS_COUNT, 32'h41, `TMC_RESP_OKAY);
    wr(`TMC_OFS_FLAGS, 32'hFF, `TMC_RESP_OKAY);
    chk(irqRequest, 3'h0);
  endtask : t_match
  // overflow at max in modes 0, 2, 3; at compare A top in mode 7
  task t_ovf;
    logic [7:0] m [4] = '{8'h01, 8'h21, 8'h31, 8'h71};
    logic [7:0] c [4] = '{8'hFE, 8'hFE, 8'hFE, 8'h0F};
    logic [7:0] f [4] = '{8'h01, 8'h01, 8'h01, 8'h03};
    logic [7:0] p [2] = '{8'h11, 8'h51};
    for (int i = 0; i < 4; i++) begin
      wr(`TMC_OFS_CTRL, {24'h0, m[i]}, `TMC_RESP_OKAY);
      wr(`TMC_OFS_COUNT, {24'h0, c[i]}, `TMC_RESP_OKAY);
      ticks(2);
      rd(`TMC_OFS_FLAGS, {24'h0, f[i]}, `TMC_RESP_OKAY);
      wr(`TMC_OFS_FLAGS, 32'h7, `TMC_RESP_OKAY);
    end
    // phase correct, modes 1 and 5: flag at bottom; turn at top driven in mode 1 only
    foreach (p[j]) begin
      wr(`TMC_OFS_CTRL, {24'h0, p[j]}, `TMC_RESP_OKAY);
      wr(`TMC_OFS_COUNT, 32'hFF, `TMC_RESP_OKAY);
      ticks(1);
      wr(`TMC_OFS_COUNT, 32'h02, `TMC_RESP_OKAY);
      ticks(2);
      rd(`TMC_OFS_FLAGS, 32'h1, `TMC_RESP_OKAY);
      wr(`TMC_OFS_FLAGS, 32'h7, `TMC_RESP_OKAY);
    end
  endtask : t_ovf
  // core enabled: request taken, vector entry clears the flag
  task t_irq;
    wr(`TMC_OFS_CTRL, 32'h01, `TMC_RESP_OKAY);
    globalIrqEnable <= 1'b1;
    ackOn <= 1'b1;
    w0 = waveA;
    wr(`TMC_OFS_COUNT, 32'h0F, `TMC_RESP_OKAY);
    ticks(2);
    chk(seenTake, 3'h2);
    chk(waveA, !w0);
    rd(`TMC_OFS_FLAGS, 32'h0, `TMC_RESP_OKAY);
    // overflow request taken and cleared by its vector entry
    wr(`TMC_OFS_COUNT, 32'hFF, `TMC_RESP_OKAY);
    ticks(1);
    chk(seenTake, 3'h3);
    rd(`TMC_OFS_FLAGS, 32'h0, `TMC_RESP_OKAY);
  endtask : t_irq
  // =====================================================================
  // main sequence
  // =====================================================================
  initial begin
    {rstn, timerTick, globalIrqEnable, ackOn} <= 4'h0;
    {awValid, wValid, bReady, arValid, rReady} <= 5'h0;
    {awAddr, arAddr, wData, wStrb} <= 52'hF;
    {fails, nChecks} = 64'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_count();
    t_match();
    t_ovf();
    t_irq();
    tally_and_finish();
  end
endmodule : test_timer8_counter_compare_irq
